/* design/aex_pkg.sv */
// Constants for the add/AND execution unit: opcodes, file map, bus map.
// Assumes a 12-bit instruction word and a 5-bit file address.
package aex_pkg;
	// Instruction cycle of four oscillator periods, phase 0..3
	localparam int unsigned OSC_PER_CYCLE = 4;
	localparam logic [1:0] PHASE_FIRST = 2'h1;
	localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);
	// Opcode fields
	localparam logic [5:0] OP_ADD_FILE = 6'h07;
	localparam logic [5:0] OP_AND_FILE = 6'h05;
	localparam logic [3:0] OP_AND_LIT = 4'he;
	localparam logic [2:0] OP_JUMP = 3'h5;
	localparam logic [8:0] OP_DIR = 9'h000;
	// File map
	localparam logic [4:0] F_TIMER = 5'h01;
	localparam logic [4:0] F_PC_LO = 5'h02;
	localparam logic [4:0] F_PORT0 = 5'h05;
	localparam logic [4:0] F_GPR0 = 5'h08;
	// Register port map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ACCUM = 4'h1;
	localparam logic [3:0] REG_FLAGS = 4'h2;
	localparam logic [3:0] REG_PC_LO = 4'h3;
	localparam logic [3:0] REG_PC_HI = 4'h4;
	localparam logic [3:0] REG_TIMER = 4'h5;
	// Field positions
	localparam int unsigned CTRL_PRESC_BIT = 0;
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_DC = 1;
	localparam int unsigned FLAG_Z = 2;
	// Reset values
	localparam logic [7:0] RST_PIN_DIRECTION_LOAD_OP = 8'hff;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_PC = 10'h000;
endpackage : aex_pkg

/* design/aex_exec.sv */
// Add/AND execution unit with file registers, port latches and direction latches.
// Assumes instr_valid and the register port come from logic on clock; pins do not.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module aex_exec #(
	parameter int unsigned NPORT = 3,
	parameter int unsigned NGPR = 24
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic instr_valid,
	input wire logic [11:0] instr,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [NPORT-1:0][7:0] io_pin_in,
	output logic [7:0] reg_rdata_ff,
	output logic [NPORT-1:0][7:0] io_out_ff,
	output logic [NPORT-1:0][7:0] io_oe_ff,
	output logic busy_ff,
	output logic done_ff,
	output logic presc_clr_ff,
	output logic [9:0] pc_ff,
	output logic [7:0] accum_ff
);
	import aex_pkg::*;

	function automatic logic is_port(input logic [4:0] f);
		is_port = (f >= F_PORT0) && (f < F_PORT0 + 5'(NPORT));
	endfunction : is_port

	//////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [NPORT-1:0][7:0] pin_s1_ff;
	logic [NPORT-1:0][7:0] pin_s2_ff;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else begin
			pin_s1_ff <= io_pin_in;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// State
	logic [1:0] phase_ff, nxt_phase;
	logic [11:0] ir_ff, nxt_ir;
	logic [7:0] nxt_accum, timer_ff, nxt_timer, nxt_rdata;
	logic [2:0] flags_ff, nxt_flags;
	logic ctrl_presc_ff, nxt_ctrl_presc, nxt_busy, nxt_done, nxt_presc_clr;
	logic [9:0] nxt_pc;
	logic [NPORT-1:0][7:0] pin_direction_load_op_ff, nxt_pin_direction_load_op, nxt_io_out, nxt_io_oe;
	logic [7:0] gpr_mem [NGPR];
	logic gpr_we;
	logic [7:0] src_val, result;
	logic [8:0] sum9;
	logic [4:0] sum_lo;
	logic [4:0] fsel;
	logic dest_file, exec, is_add, is_andf, is_andl, is_jump, is_dir;

	assign fsel = ir_ff[4:0];
	assign dest_file = ir_ff[5];
	assign exec = busy_ff && (phase_ff == PHASE_LAST);
	assign is_add = ir_ff[11:6] == OP_ADD_FILE;
	assign is_andf = ir_ff[11:6] == OP_AND_FILE;
	assign is_andl = ir_ff[11:8] == OP_AND_LIT;
	assign is_jump = ir_ff[11:9] == OP_JUMP;
	assign is_dir = (ir_ff[11:3] == OP_DIR) && is_port({2'h0, ir_ff[2:0]});

	//////////////////////////////////////////////////////////////////////////////
	// Operand fetch and arithmetic
	always_comb begin
		src_val = 8'h00;
		if (fsel == F_TIMER) begin
			src_val = timer_ff;
		end else if (fsel == F_PC_LO) begin
			src_val = pc_ff[7:0];
		end else if (is_port(fsel)) begin
			src_val = pin_s2_ff[fsel - F_PORT0];
		end else if (fsel >= F_GPR0 && (fsel - F_GPR0) < 5'(NGPR)) begin
			src_val = gpr_mem[fsel - F_GPR0];
		end
		if (is_andl) begin
			src_val = ir_ff[7:0];
		end
		sum9 = {1'b0, accum_ff} + {1'b0, src_val};
		sum_lo = {1'b0, accum_ff[3:0]} + {1'b0, src_val[3:0]};
		result = is_add ? sum9[7:0] : (accum_ff & src_val);
	end

	//////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		nxt_phase = phase_ff;
		nxt_ir = ir_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_presc_clr = 1'b0;
		nxt_accum = accum_ff;
		nxt_flags = flags_ff;
		nxt_timer = timer_ff;
		nxt_pc = pc_ff;
		nxt_pin_direction_load_op = pin_direction_load_op_ff;
		nxt_io_out = io_out_ff;
		nxt_ctrl_presc = ctrl_presc_ff;
		nxt_rdata = 8'h00;
		gpr_we = 1'b0;
		if (!busy_ff && instr_valid) begin
			nxt_ir = instr;
			nxt_busy = 1'b1;
			nxt_phase = PHASE_FIRST;
		end else if (busy_ff) begin
			nxt_phase = phase_ff + 2'h1;
		end
		if (exec) begin
			nxt_busy = 1'b0;
			nxt_done = 1'b1;
			if (is_add || is_andf || is_andl) begin
				nxt_flags[FLAG_Z] = (result == 8'h00);
				if (is_add) begin
					nxt_flags[FLAG_C] = sum9[8];
					nxt_flags[FLAG_DC] = sum_lo[4];
				end
			end
			if ((is_add || is_andf) && dest_file) begin
				if (fsel == F_TIMER) begin
					nxt_timer = result;
					nxt_presc_clr = ctrl_presc_ff;
				end else if (fsel == F_PC_LO) begin
					// Ninth bit is pc[8]; only the jump may load it from its operand
					nxt_pc = {pc_ff[9], 1'b0, result};
				end else if (is_port(fsel)) begin
					nxt_io_out[fsel - F_PORT0] = result;
				end else if (fsel >= F_GPR0) begin
					gpr_we = 1'b1;
				end
			end else if (is_add || is_andf || is_andl) begin
				nxt_accum = result;
			end
			if (is_jump) begin
				nxt_pc = {pc_ff[9], ir_ff[8:0]};
			end
			if (is_dir) begin
				nxt_pin_direction_load_op[ir_ff[2:0] - 3'(F_PORT0)] = accum_ff;
			end
		end
		// Software writes yield to a committing instruction
		if (reg_wr && !exec) begin
			unique case (reg_addr)
				REG_CTRL: nxt_ctrl_presc = reg_wdata[CTRL_PRESC_BIT];
				REG_ACCUM: nxt_accum = reg_wdata;
				REG_TIMER: nxt_timer = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: nxt_rdata = {7'h00, ctrl_presc_ff};
				REG_ACCUM: nxt_rdata = accum_ff;
				REG_FLAGS: nxt_rdata = {5'h00, flags_ff};
				REG_PC_LO: nxt_rdata = pc_ff[7:0];
				REG_PC_HI: nxt_rdata = {6'h00, pc_ff[9:8]};
				REG_TIMER: nxt_rdata = timer_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
		for (int i = 0; i < NPORT; i++) begin
			nxt_io_oe[i] = ~nxt_pin_direction_load_op[i];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			phase_ff <= 2'h0;
			ir_ff <= 12'h000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			presc_clr_ff <= 1'b0;
			accum_ff <= RST_BYTE;
			flags_ff <= 3'h0;
			timer_ff <= RST_BYTE;
			pc_ff <= RST_PC;
			pin_direction_load_op_ff <= {NPORT{RST_PIN_DIRECTION_LOAD_OP}};
			io_out_ff <= '0;
			io_oe_ff <= '0;
			ctrl_presc_ff <= 1'b0;
			reg_rdata_ff <= 8'h00;
		end else begin
			phase_ff <= nxt_phase;
			ir_ff <= nxt_ir;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			presc_clr_ff <= nxt_presc_clr;
			accum_ff <= nxt_accum;
			flags_ff <= nxt_flags;
			timer_ff <= nxt_timer;
			pc_ff <= nxt_pc;
			pin_direction_load_op_ff <= nxt_pin_direction_load_op;
			io_out_ff <= nxt_io_out;
			io_oe_ff <= nxt_io_oe;
			ctrl_presc_ff <= nxt_ctrl_presc;
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// General-purpose file; contents are undefined after reset, as in the core
	always_ff @(posedge clock) begin
		if (gpr_we) begin
			gpr_mem[fsel - F_GPR0] <= result;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_cycle;
		@(posedge clock) disable iff (!rstn)
		(!busy_ff && instr_valid) |=> busy_ff [*3] ##1 (done_ff && !busy_ff);
	endproperty
	a_cycle: assert property (p_cycle) else $error("instruction not four clocks");

	property p_pc_clear;
		@(posedge clock) disable iff (!rstn)
		(exec && (is_add || is_andf) && dest_file && fsel == F_PC_LO)
			|=> (pc_ff[8] == 1'b0) && (pc_ff[9] == $past(pc_ff[9]))
			&& (pc_ff[7:0] == $past(result));
	endproperty
	a_pc_clear: assert property (p_pc_clear) else $error("pc ninth bit not cleared");

	property p_jump;
		@(posedge clock) disable iff (!rstn)
		(exec && is_jump) |=> pc_ff == {$past(pc_ff[9]), $past(ir_ff[8:0])};
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong");

	property p_pin_rmw;
		@(posedge clock) disable iff (!rstn)
		(exec && is_andf && dest_file && fsel == F_PORT0 + 5'h01)
			|=> io_out_ff[1] == ($past(accum_ff) & $past(pin_s2_ff[1]));
	endproperty
	a_pin_rmw: assert property (p_pin_rmw) else $error("port write-back not from pins");

	property p_dir_load;
		@(posedge clock) disable iff (!rstn)
		(exec && is_dir && ir_ff[2:0] == 3'h6) |=> ##1 io_oe_ff[1] == ~$past(accum_ff, 2);
	endproperty
	a_dir_load: assert property (p_dir_load) else $error("direction load wrong");

	property p_oe;
		@(posedge clock) disable iff (!rstn)
		##1 (io_oe_ff == ~pin_direction_load_op_ff);
	endproperty
	a_oe: assert property (p_oe) else $error("driver enable disagrees with latch");

	property p_presc;
		@(posedge clock) disable iff (!rstn)
		presc_clr_ff |-> $past(exec && dest_file && fsel == F_TIMER && ctrl_presc_ff);
	endproperty
	a_presc: assert property (p_presc) else $error("prescaler clear without cause");

	property p_add;
		@(posedge clock) disable iff (!rstn)
		(exec && is_add && !dest_file)
			|=> {flags_ff[FLAG_C], accum_ff} == ({1'b0, $past(accum_ff)} + {1'b0, $past(src_val)});
	endproperty
	a_add: assert property (p_add) else $error("add result or carry wrong");

	property p_and_lit;
		@(posedge clock) disable iff (!rstn)
		(exec && is_andl) |=> (accum_ff == ($past(accum_ff) & $past(ir_ff[7:0])))
			&& (flags_ff[FLAG_Z] == (accum_ff == 8'h00)) && $stable(flags_ff[1:0]);
	endproperty
	a_and_lit: assert property (p_and_lit) else $error("literal and wrong");

	property p_zero;
		@(posedge clock) disable iff (!rstn)
		(exec && is_andf) |=> flags_ff[FLAG_Z] == ($past(result) == 8'h00)
			&& flags_ff[FLAG_C] == $past(flags_ff[FLAG_C]);
	endproperty
	a_zero: assert property (p_zero) else $error("and flags wrong");
endmodule : aex_exec

/* testbench/aex_exec_tb.sv */
// Self-checking bench for the add/AND execution unit.
// Assumes the bench drives instructions, pins and the register port itself.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module aex_exec_tb;
	import aex_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic instr_valid = 1'b0;
	logic [11:0] instr = 12'h000;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [2:0][7:0] io_pin_in = '0;
	logic [7:0] reg_rdata_ff;
	logic [2:0][7:0] io_out_ff;
	logic [2:0][7:0] io_oe_ff;
	logic busy_ff, done_ff, presc_clr_ff;
	logic [9:0] pc_ff;
	logic [7:0] accum_ff, v;
	logic pclr;
	int error_cnt = 0;
	int checks = 0;
	aex_exec DUT (.clock(clock), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.io_pin_in(io_pin_in), .reg_rdata_ff(reg_rdata_ff), .io_out_ff(io_out_ff),
		.io_oe_ff(io_oe_ff), .busy_ff(busy_ff), .done_ff(done_ff),
		.presc_clr_ff(presc_clr_ff), .pc_ff(pc_ff), .accum_ff(accum_ff));
	always #5 clock = ~clock;
	//////////////////////////////////////////////////////////////////////////////
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_ff;
	endtask : rd
	// Pins pass two flops, so they are settled well before the instruction
	task pins(input int p, input logic [7:0] d);
		@(posedge clock);
		io_pin_in[p] <= d;
		repeat (3) @(posedge clock);
	endtask : pins
	task exec(input logic [11:0] w);
		int n;
		@(posedge clock);
		instr <= w;
		instr_valid <= 1'b1;
		@(posedge clock);
		instr_valid <= 1'b0;
		n = 1;
		#1;
		`CHK(busy_ff, 1'b1)
		while (done_ff !== 1'b1 && n < 10) begin
			@(posedge clock);
			#1 n++;
		end
		pclr = presc_clr_ff;
		`CHK(n, 4)
		`CHK(busy_ff, 1'b0)
	endtask : exec
	//////////////////////////////////////////////////////////////////////////////
	task t_reset;
		`CHK(io_oe_ff, 24'h000000)
		`CHK(pc_ff, 10'h000)
		rd(4'hf, v);
		`CHK(v, 8'h00)
		$display("reset done");
	endtask : t_reset
	task t_add;
		wr(REG_ACCUM, 8'h17);
		pins(0, 8'hc2);
		exec({OP_ADD_FILE, 1'b0, F_PORT0});
		`CHK(accum_ff, 8'hd9)
		rd(REG_FLAGS, v);
		`CHK(v, 8'h00)
		wr(REG_ACCUM, 8'hff);
		pins(0, 8'h01);
		exec({OP_ADD_FILE, 1'b1, F_PORT0});
		`CHK(io_out_ff[0], 8'h00)
		`CHK(accum_ff, 8'hff)
		rd(REG_FLAGS, v);
		`CHK(v, 8'h07)
		$display("add done");
	endtask : t_add
	task t_and;
		wr(REG_ACCUM, 8'h17);
		pins(1, 8'hc2);
		exec({OP_AND_FILE, 1'b1, 5'h06});
		`CHK(io_out_ff[1], 8'h02)
		rd(REG_FLAGS, v);
		`CHK(v, 8'h03)
		// Latch now holds 0x02; the pins must win the read-back
		wr(REG_ACCUM, 8'hff);
		pins(1, 8'hf0);
		exec({OP_AND_FILE, 1'b1, 5'h06});
		`CHK(io_out_ff[1], 8'hf0)
		wr(REG_ACCUM, 8'ha3);
		exec({OP_AND_LIT, 8'h5f});
		`CHK(accum_ff, 8'h03)
		exec({OP_AND_LIT, 8'h00});
		`CHK(accum_ff, 8'h00)
		rd(REG_FLAGS, v);
		`CHK(v, 8'h07)
		$display("and done");
	endtask : t_and
	task t_dir;
		for (int i = 0; i < 3; i++) begin
			wr(REG_ACCUM, 8'h5a + 8'(i));
			exec({OP_DIR, 3'(5 + i)});
			`CHK(io_oe_ff[i], ~(8'h5a + 8'(i)))
		end
		$display("direction done");
	endtask : t_dir
	task t_pc;
		exec({OP_JUMP, 9'h1ff});
		`CHK(pc_ff, 10'h1ff)
		wr(REG_ACCUM, 8'h10);
		exec({OP_ADD_FILE, 1'b1, F_PC_LO});
		`CHK(pc_ff, 10'h00f)
		rd(REG_PC_HI, v);
		`CHK(v, 8'h00)
		$display("pc done");
	endtask : t_pc
	task t_presc;
		wr(REG_CTRL, 8'h01);
		wr(REG_ACCUM, 8'h00);
		exec({OP_ADD_FILE, 1'b1, F_TIMER});
		`CHK(pclr, 1'b1)
		exec({OP_ADD_FILE, 1'b0, F_TIMER});
		`CHK(pclr, 1'b0)
		wr(REG_CTRL, 8'h00);
		exec({OP_AND_FILE, 1'b1, F_TIMER});
		`CHK(pclr, 1'b0)
		$display("prescaler done");
	endtask : t_presc
	// General file starts unknown, so it is cleared by an AND with zero first
	task t_gpr;
		wr(REG_ACCUM, 8'h00);
		exec({OP_AND_FILE, 1'b1, F_GPR0});
		wr(REG_ACCUM, 8'h35);
		exec({OP_ADD_FILE, 1'b1, F_GPR0});
		exec({OP_ADD_FILE, 1'b0, F_GPR0});
		`CHK(accum_ff, 8'h6a)
		exec({OP_ADD_FILE, 1'b0, 5'h00});
		`CHK(accum_ff, 8'h6a)
		rd(REG_ACCUM, v);
		`CHK(v, 8'h6a)
		$display("file done");
	endtask : t_gpr
	//////////////////////////////////////////////////////////////////////////////
	task end_sim;
		$display("checks=%0d mismatches=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		#1;
		t_reset();
		t_add();
		t_and();
		t_dir();
		t_pc();
		t_presc();
		t_gpr();
		end_sim();
	end
endmodule : aex_exec_tb
